/* File: esf_pkg.sv */
// Summary of operation
// RQ1 - Reads and writes happen only on clock edges.
// RQ2 - Port timing independent; clock up to 250 MHz. Here both ports share the one clock_i.
// RQ3 - Dual-port shapes 4kx1, 2kx2, 1kx4, 512x9.
// RQ4 - Two-port shapes 512x9 and 256x18.
// RQ5 - Synchronous write; pipelined or plain synchronous read.
// RQ6 - Restricted variant: inverted same-source clocks only.
// RQ7 - Restricted variant single-port: ground unused port.
// RQ8 - FIFO controller generates memory addresses internally.
// RQ9 - FIFO drives full, empty, almost-full, almost-empty.
// RQ10 - Same-address dual access allowed under timing limits.
// RQ11 - RAM mode uses user addresses, ignores FIFO.
// RQ12 - FIFO mode muxes controller addresses into array.
// RQ13 - Write and read widths may differ.
// RQ14 - Separate write-width and read-width selects, five shapes.
// RQ15 - Narrow widths leave ninth bit unused.
// RQ16 - Nine-bit write, four-bit read: low/high nibbles.
// RQ17 - Four-bit write, nine-bit read: ninth bit undefined.
// RQ18 - Narrow sub-words packed little-endian into wide words.
// RQ19 - Read/write select: low writes, high reads.
// RQ20 - Pipe low: data same cycle; high: next.
// RQ21 - Reset clears control and outputs, keeps array.
// RQ22 - Block select high: no operation, outputs hold.
// RQ23 - FIFO flags update on the changing port's clock.
package esf_pkg;

  // ****************************************************************
  // Geometry, timing and bus constants
  // ****************************************************************
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned WORD_W     = 9;
  localparam int unsigned WORDS      = 512;
  localparam int unsigned DATA_W     = 18;
  localparam int unsigned PTR_W      = 13;
  localparam int unsigned AXI_ADDR_W = 8;
  localparam int unsigned CLK_MHZ    = 250;
  localparam logic [12:0] CAPACITY   = 13'h1000;

  // Register offsets, field positions and reset values.
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_THRESH  = 8'h04;
  localparam logic [7:0]  REG_STATUS  = 8'h08;
  localparam int unsigned CTRL_MODE   = 0;
  localparam int unsigned CTRL_WWID_LSB = 1;
  localparam int unsigned CTRL_RW_LSB = 4;
  localparam int unsigned CTRL_CLEAR  = 8;
  localparam int unsigned THR_AF_LSB  = 0;
  localparam int unsigned THR_AE_LSB  = 16;
  localparam int unsigned STAT_LV_LSB = 16;
  localparam logic [12:0] AF_THR_RST  = 13'h0F00;
  localparam logic [12:0] AE_THR_RST  = 13'h0100;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ESF_W1  = 3'h0,
    ESF_W2  = 3'h1,
    ESF_W4  = 3'h2,
    ESF_W9  = 3'h3,
    ESF_W18 = 3'h4
  } esf_width_t;

  typedef struct packed {
    logic        block_select_n;
    logic        read_write_select;
    logic        output_register_select;
    logic [11:0] addr;
    logic [17:0] wdata;
  } esf_port_req_t;

  typedef struct packed {
    logic full;
    logic empty;
    logic almost_full_flag;
    logic almost_empty_flag;
  } esf_flags_t;

  // ****************************************************************
  // Width decoding shared by the array and the FIFO controller
  // ****************************************************************
  // Word holding the low end of an access; codes 5..7 act as nine bits.
  function automatic logic [8:0] esf_word_base(esf_width_t w, logic [11:0] a);
    case (w)
      ESF_W1:  return a[11:3];
      ESF_W2:  return a[10:2];
      ESF_W4:  return a[9:1];
      ESF_W18: return {a[7:0], 1'b0};
      default: return a[8:0];
    endcase
  endfunction

  // Bit offset inside the word; lower addresses take lower bits.
  function automatic logic [2:0] esf_bit_off(esf_width_t w, logic [11:0] a);
    case (w)
      ESF_W1:  return a[2:0];
      ESF_W2:  return {a[1:0], 1'b0};
      ESF_W4:  return {a[0], 2'b00};
      default: return 3'h0;
    endcase
  endfunction

  function automatic logic [17:0] esf_mask(esf_width_t w);
    case (w)
      ESF_W1:  return 18'h00001;
      ESF_W2:  return 18'h00003;
      ESF_W4:  return 18'h0000F;
      ESF_W18: return 18'h3FFFF;
      default: return 18'h001FF;
    endcase
  endfunction

  // Pointer step in one-bit address units; a nine-bit word counts eight.
  function automatic logic [12:0] esf_step(esf_width_t w);
    case (w)
      ESF_W1:  return 13'h0001;
      ESF_W2:  return 13'h0002;
      ESF_W4:  return 13'h0004;
      ESF_W18: return 13'h0010;
      default: return 13'h0008;
    endcase
  endfunction

  function automatic logic [11:0] esf_ptr_addr(esf_width_t w, logic [12:0] p);
    case (w)
      ESF_W1:  return p[11:0];
      ESF_W2:  return {1'b0, p[11:1]};
      ESF_W4:  return {2'b00, p[11:2]};
      ESF_W18: return {4'h0, p[11:4]};
      default: return {3'h0, p[11:3]};
    endcase
  endfunction

  function automatic logic [31:0] esf_merge(logic [31:0] o, logic [31:0] n,
                                            logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

/* File: esf_fifo_ctrl.sv */
`timescale 1ns/1ps
module esf_fifo_ctrl (
  input  wire logic               clock_i,
  input  wire logic               srst_i,
  input  wire logic               clear_i,
  input  wire logic               push_i,
  input  wire logic               pop_i,
  input  wire esf_pkg::esf_width_t wwidth_i,
  input  wire esf_pkg::esf_width_t rwidth_i,
  input  wire logic [12:0]        af_thr_i,
  input  wire logic [12:0]        ae_thr_i,
  output logic [11:0]             waddr_o,
  output logic [11:0]             raddr_o,
  output esf_pkg::esf_flags_t     flags_o,
  output logic [12:0]             level_o
);
  import esf_pkg::*;

  logic [12:0] wptr_r;
  logic [12:0] rptr_r;
  wire  [12:0] wptr_nxt  = push_i ? 13'(wptr_r + esf_step(wwidth_i)) : wptr_r;
  wire  [12:0] rptr_nxt  = pop_i ? 13'(rptr_r + esf_step(rwidth_i)) : rptr_r;
  wire  [12:0] level_nxt = 13'(wptr_nxt - rptr_nxt);

  // Addresses come from the pointers, never from the user pins. [RQ8]
  assign waddr_o = esf_ptr_addr(wwidth_i, wptr_r);
  assign raddr_o = esf_ptr_addr(rwidth_i, rptr_r);

  // ****************************************************************
  // Pointers and flags
  // ****************************************************************
  // Flags are registered from the next level, so a push or pop shows at
  // the same edge; one clock serves both sides here. [RQ9] [RQ23]
  always_ff @(posedge clock_i) begin
    if (srst_i || clear_i) begin
      wptr_r  <= 13'h0000;
      rptr_r  <= 13'h0000;
      level_o <= 13'h0000;
      flags_o <= '{full: 1'b0, empty: 1'b1, almost_full_flag: 1'b0,
                   almost_empty_flag: 1'b1};
    end else begin
      wptr_r                    <= wptr_nxt;
      rptr_r                    <= rptr_nxt;
      level_o                   <= level_nxt;
      flags_o.full              <= 13'(CAPACITY - level_nxt) < esf_step(wwidth_i);
      flags_o.empty             <= level_nxt < esf_step(rwidth_i);
      flags_o.almost_full_flag  <= level_nxt >= af_thr_i;
      flags_o.almost_empty_flag <= level_nxt <= ae_thr_i;
    end
  end

  AST_LEVEL_BOUND: assert property (@(posedge clock_i) disable iff (srst_i) // [RQ9]
    level_o <= CAPACITY)
    else $error("FIFO level above capacity.");

  AST_EMPTY_MATCH: assert property (@(posedge clock_i) disable iff (srst_i) // [RQ23]
    !$past(clear_i) && $past(pop_i) && $past(level_nxt) == 13'h0000 |-> flags_o.empty)
    else $error("Empty flag missing after draining pop.");

endmodule

/* File: esf_sram.sv */
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module esf_sram (
  input  wire logic                   clock_i,
  input  wire logic                   srst_i,
  input  wire logic [7:0]             s_axi_awaddr_i,
  input  wire logic                   s_axi_awvalid_i,
  output logic                        s_axi_awready_o,
  input  wire logic [31:0]            s_axi_wdata_i,
  input  wire logic [3:0]             s_axi_wstrb_i,
  input  wire logic                   s_axi_wvalid_i,
  output logic                        s_axi_wready_o,
  output logic [1:0]                  s_axi_bresp_o,
  output logic                        s_axi_bvalid_o,
  input  wire logic                   s_axi_bready_i,
  input  wire logic [7:0]             s_axi_araddr_i,
  input  wire logic                   s_axi_arvalid_i,
  output logic                        s_axi_arready_o,
  output logic [31:0]                 s_axi_rdata_o,
  output logic [1:0]                  s_axi_rresp_o,
  output logic                        s_axi_rvalid_o,
  input  wire logic                   s_axi_rready_i,
  input  wire esf_pkg::esf_port_req_t port_a_req_i,
  input  wire esf_pkg::esf_port_req_t port_b_req_i,
  output logic [17:0]                 port_a_rdata_o,
  output logic [17:0]                 port_b_rdata_o,
  output esf_pkg::esf_flags_t         fifo_flags_o
);
  import esf_pkg::*;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic        fifo_mode_r;
  esf_width_t  write_width_select_r;
  esf_width_t  read_width_select_r;
  logic        clear_r;
  logic [12:0] af_thr_r;
  logic [12:0] ae_thr_r;
  logic [12:0] level;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        aw_held_r;
  logic        w_held_r;

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  // One write and one read at a time; each ready drops once its item is
  // taken and rises again when the response is accepted.
  wire        wr_fire   = aw_held_r && w_held_r && !s_axi_bvalid_o;
  wire [7:0]  wr_reg    = {awaddr_r[7:2], 2'b00};
  wire [7:0]  rd_reg    = {s_axi_araddr_i[7:2], 2'b00};
  wire        ar_take   = s_axi_arvalid_i && s_axi_arready_o;
  // Bit 7 is spare, so the clear pulse reads back at bit 8.
  wire [31:0] ctrl_img  = {23'h000000, clear_r, 1'b0, read_width_select_r,
                           write_width_select_r, fifo_mode_r};
  wire [31:0] thr_img   = {3'h0, ae_thr_r, 3'h0, af_thr_r};
  wire [31:0] ctrl_new  = esf_merge(ctrl_img, wdata_r, wstrb_r);
  wire [31:0] thr_new   = esf_merge(thr_img, wdata_r, wstrb_r);
  wire        wr_ctrl   = wr_fire && wr_reg == REG_CTRL;
  wire        wr_thr    = wr_fire && wr_reg == REG_THRESH;
  wire        wr_known  = wr_reg == REG_CTRL || wr_reg == REG_THRESH;
  wire        rd_known  = rd_reg == REG_CTRL || rd_reg == REG_THRESH ||
                          rd_reg == REG_STATUS;
  wire [31:0] status_img = {3'h0, level, 12'h000, fifo_flags_o.almost_empty_flag,
                            fifo_flags_o.almost_full_flag, fifo_flags_o.empty,
                            fifo_flags_o.full};
  wire [31:0] rd_word   = rd_reg == REG_CTRL   ? ctrl_img :
                          rd_reg == REG_THRESH ? thr_img :
                          rd_reg == REG_STATUS ? status_img : 32'h00000000;

  // Write address and data channels are caught independently.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      aw_held_r       <= 1'b0;
      w_held_r        <= 1'b0;
      awaddr_r        <= 8'h00;
      wdata_r         <= 32'h00000000;
      wstrb_r         <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_r       <= 1'b1;
        awaddr_r        <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_r       <= 1'b1;
        wdata_r        <= s_axi_wdata_i;
        wstrb_r        <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_r      <= 1'b0;
        w_held_r       <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h00000000;
      s_axi_rresp_o   <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= rd_word;
      s_axi_rresp_o   <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // Widths are meant to be set before traffic; changing them mid-stream
  // reinterprets the FIFO pointers. The clear bit is a one-cycle pulse.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      fifo_mode_r          <= 1'b0;
      write_width_select_r <= ESF_W9;
      read_width_select_r  <= ESF_W9;
      clear_r              <= 1'b0;
      af_thr_r             <= AF_THR_RST;
      ae_thr_r             <= AE_THR_RST;
    end else begin
      clear_r <= wr_ctrl && ctrl_new[CTRL_CLEAR];
      if (wr_ctrl) begin // [RQ14]
        fifo_mode_r          <= ctrl_new[CTRL_MODE];
        write_width_select_r <= esf_width_t'(ctrl_new[CTRL_WWID_LSB +: 3]);
        read_width_select_r  <= esf_width_t'(ctrl_new[CTRL_RW_LSB +: 3]);
      end
      if (wr_thr) begin
        af_thr_r <= thr_new[THR_AF_LSB +: 13];
        ae_thr_r <= thr_new[THR_AE_LSB +: 13];
      end
    end
  end

  // ****************************************************************
  // Port decode and address selection
  // ****************************************************************
  esf_port_req_t req [2];
  esf_width_t    wid [2];
  logic [11:0]   addr_sel [2];
  logic [8:0]    base [2];
  logic [2:0]    off [2];
  logic [17:0]   wmask [2];
  logic [17:0]   wbits [2];
  logic [17:0]   rbits [2];
  logic [17:0]   stage_r [2];
  logic [17:0]   out_r [2];
  logic [1:0]    pend_r;
  logic [1:0]    en;
  logic [1:0]    we;
  logic [1:0]    re;
  logic [11:0]   fifo_waddr;
  logic [11:0]   fifo_raddr;
  logic [8:0]    mem [WORDS];

  assign req[0] = port_a_req_i;
  assign req[1] = port_b_req_i;
  // Port A carries the write width, port B the read width. [RQ13] [RQ14]
  assign wid[0] = write_width_select_r;
  assign wid[1] = read_width_select_r;
  // Deselected ports and ports under reset do nothing. [RQ21] [RQ22]
  assign en[0] = !req[0].block_select_n && !srst_i;
  assign en[1] = !req[1].block_select_n && !srst_i;
  // Low selects write, high selects read; FIFO mode fixes A as the
  // writer, B as the reader, and refuses writes when full, reads when
  // empty. [RQ19] [RQ9]
  assign we[0] = en[0] && !req[0].read_write_select && !(fifo_mode_r && fifo_flags_o.full);
  assign re[0] = en[0] && req[0].read_write_select && !fifo_mode_r;
  assign we[1] = en[1] && !req[1].read_write_select && !fifo_mode_r;
  assign re[1] = en[1] && req[1].read_write_select && !(fifo_mode_r && fifo_flags_o.empty);
  // User addresses in RAM mode, controller addresses in FIFO mode. [RQ11] [RQ12]
  assign addr_sel[0] = fifo_mode_r ? fifo_waddr : req[0].addr;
  assign addr_sel[1] = fifo_mode_r ? fifo_raddr : req[1].addr;

  esf_fifo_ctrl u_fifo (
    .clock_i      (clock_i),
    .srst_i       (srst_i),
    .clear_i      (clear_r),
    .push_i       (fifo_mode_r && we[0]),
    .pop_i        (fifo_mode_r && re[1]),
    .wwidth_i     (write_width_select_r),
    .rwidth_i     (read_width_select_r),
    .af_thr_i     (af_thr_r),
    .ae_thr_i     (ae_thr_r),
    .waddr_o      (fifo_waddr),
    .raddr_o      (fifo_raddr),
    .flags_o      (fifo_flags_o),
    .level_o      (level)
  );

  // ****************************************************************
  // Array and read paths
  // ****************************************************************
  // Shapes 4kx1..512x9 on either port, 256x18 spans a word pair; narrow
  // widths pack little-endian into bits 7..0 and never touch bit 8.
  // [RQ3] [RQ4] [RQ15] [RQ16] [RQ17] [RQ18]
  for (genvar p = 0; p < 2; p++) begin : g_port
    assign base[p]  = esf_word_base(wid[p], addr_sel[p]);
    assign off[p]   = esf_bit_off(wid[p], addr_sel[p]);
    assign wmask[p] = esf_mask(wid[p]) << off[p];
    assign wbits[p] = req[p].wdata << off[p];
    assign rbits[p] = ({mem[9'(base[p] + 9'h001)], mem[base[p]]} >> off[p]) & esf_mask(wid[p]);

    // Plain reads register array data at the edge; pipelined reads add
    // one more stage, so data shows one cycle later. [RQ5] [RQ20] [RQ1]
    always_ff @(posedge clock_i) begin
      if (srst_i) begin
        stage_r[p] <= 18'h00000;
        out_r[p]   <= 18'h00000;
        pend_r[p]  <= 1'b0;
      end else begin
        pend_r[p] <= re[p] && req[p].output_register_select;
        if (re[p]) begin
          stage_r[p] <= rbits[p];
        end
        if (re[p] && !req[p].output_register_select) begin
          out_r[p] <= rbits[p];
        end else if (pend_r[p]) begin
          out_r[p] <= stage_r[p];
        end
      end
    end

    AST_PLAIN_READ: assert property (@(posedge clock_i) disable iff (srst_i) // [RQ20]
      re[p] && !req[p].output_register_select |=> out_r[p] == $past(rbits[p]))
      else $error("Plain read data not on output after one edge.");

    AST_PIPE_READ: assert property (@(posedge clock_i) disable iff (srst_i) // [RQ5]
      re[p] && req[p].output_register_select ##1 !(re[p] && !req[p].output_register_select)
      |=> out_r[p] == $past(rbits[p], 2))
      else $error("Pipelined read data not on output one cycle later.");

    AST_DESELECT_HOLD: assert property (@(posedge clock_i) disable iff (srst_i) // [RQ22]
      req[p].block_select_n && !pend_r[p] |=> $stable(out_r[p]))
      else $error("Output moved while port deselected.");

    AST_RESET_CLEAR: assert property (@(posedge clock_i) // [RQ21]
      srst_i |-> (!we[p] && !re[p]) ##1 (out_r[p] == 18'h00000))
      else $error("Port active or output not cleared under reset.");
  end

  // Both ports may write one address in a cycle; port B lands last, and
  // avoiding such collisions is the user's timing duty. [RQ10] [RQ1] [RQ2]
  always_ff @(posedge clock_i) begin
    for (int p = 0; p < 2; p++) begin
      for (int b = 0; b < 18; b++) begin
        if (we[p] && wmask[p][b]) begin
          mem[9'(base[p] + 9'(b / 9))][b % 9] <= wbits[p][b];
        end
      end
    end
  end

  assign port_a_rdata_o = out_r[0];
  assign port_b_rdata_o = out_r[1];

  AST_RAM_ADDR: assert property (@(posedge clock_i) disable iff (srst_i) // [RQ11]
    !fifo_mode_r |-> addr_sel[0] == port_a_req_i.addr && addr_sel[1] == port_b_req_i.addr)
    else $error("RAM mode not using user addresses.");

  AST_FIFO_ADDR: assert property (@(posedge clock_i) disable iff (srst_i) // [RQ12]
    fifo_mode_r && we[0] && !clear_r && !wr_ctrl |=> addr_sel[0] != $past(addr_sel[0]))
    else $error("FIFO write address did not advance after a push.");

  AST_FULL_REFUSE: assert property (@(posedge clock_i) disable iff (srst_i) // [RQ9]
    fifo_mode_r && fifo_flags_o.full |-> !we[0] && !we[1])
    else $error("Write accepted while FIFO full.");

  AST_EMPTY_REFUSE: assert property (@(posedge clock_i) disable iff (srst_i) // [RQ9]
    fifo_mode_r && fifo_flags_o.empty |-> !re[1] && !re[0])
    else $error("Read accepted while FIFO empty.");

  AST_WRITE_RESP: assert property (@(posedge clock_i) disable iff (srst_i) // [RQ14]
    wr_fire |=> s_axi_bvalid_o && !aw_held_r && !w_held_r)
    else $error("Write response not raised one cycle after both channels held.");

endmodule

/* File: esf_user_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Fabric-side user logic driving both memory ports
// ****************************************************************
module esf_user_model (
  input  wire logic              clock_i,
  output esf_pkg::esf_port_req_t port_a_req_o,
  output esf_pkg::esf_port_req_t port_b_req_o
);
  import esf_pkg::*;

  // Both ports start deselected so nothing happens during reset.
  initial begin
    port_a_req_o = {3'b110, 12'h000, 18'h00000};
    port_b_req_o = {3'b110, 12'h000, 18'h00000};
  end

  // One access on one port; both ports share one clock and take turns,
  // so same-address timing between them is met by construction.
  task automatic acc(input logic pb, input logic sn, input logic rw, input logic pp,
                     input logic [11:0] a, input logic [17:0] d);
    esf_port_req_t r;
    r = {sn, rw, pp, a, d}; // Low selects a write, high a read.
    @(posedge clock_i);
    if (pb) port_b_req_o <= r;
    else port_a_req_o <= r;
    @(posedge clock_i);
    // Released lines show the inverse, so a stale value cannot pass.
    r = {1'b1, rw, pp, ~a, ~d};
    if (pb) port_b_req_o <= r;
    else port_a_req_o <= r;
  endtask
endmodule

/* File: esf_sram_tb.sv */
`timescale 1ns/1ps
module esf_sram_tb;
  import esf_pkg::*;
  // ****************************************************************
  // Stimulus, design and partner
  // ****************************************************************
  logic          clock_i = 1'b0;
  logic          srst_i  = 1'b1;
  logic [7:0]    awaddr  = 8'h00, araddr = 8'h00;
  logic [31:0]   wdata   = 32'h0, rdata;
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic          awready, wready, bvalid, arready, rvalid;
  logic [1:0]    bresp, rresp;
  logic [17:0]   a_rd, b_rd;
  esf_flags_t    flags;
  esf_port_req_t a_req, b_req;
  int            miscompares = 0, check_count = 0, cyc = 0;
  localparam logic [17:0] WD = 18'h2B1C3;

  esf_user_model m (.clock_i(clock_i), .port_a_req_o(a_req), .port_b_req_o(b_req));
  esf_sram dut_u (.clock_i(clock_i), .srst_i(srst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .port_a_req_i(a_req), .port_b_req_i(b_req),
    .port_a_rdata_o(a_rd), .port_b_rdata_o(b_rd), .fifo_flags_o(flags));

  // Clock at 4 ns; a hang is cut short after a fixed cycle ceiling.
  initial begin
    forever #2 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      end_sim();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic end_sim();
    if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] ctl(input logic f, input esf_width_t w, input esf_width_t r);
    return (32'(f) << CTRL_MODE) | (32'(w) << CTRL_WWID_LSB) | (32'(r) << CTRL_RW_LSB);
  endfunction
  // Address and data are offered together, each released when taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clock_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    bready <= 1'b1;
    do @(posedge clock_i); while (!bvalid);
    chk(32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clock_i); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clock_i); while (!rvalid);
    chk(rdata, e);
    chk(32'(rresp), 32'(er));
    rready <= 1'b0;
  endtask
  // Port read; a pipelined read still shows the old word after the taking edge.
  task automatic rd(input logic pb, input logic pp, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] old;
    old = pb ? 32'(b_rd) : 32'(a_rd);
    m.acc(pb, 1'b0, 1'b1, pp, a, 18'h00000);
    #1;
    if (pp) begin
      chk(pb ? 32'(b_rd) : 32'(a_rd), old);
      @(posedge clock_i);
      #1;
    end
    chk(pb ? 32'(b_rd) : 32'(a_rd), e);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    chk(32'(flags), 32'h5);
    chk(32'(b_rd), 32'h0);
    axi_rd(REG_CTRL, ctl(1'b0, ESF_W9, ESF_W9), RESP_OKAY);
    axi_rd(REG_THRESH, (32'(AE_THR_RST) << THR_AE_LSB) | 32'(AF_THR_RST), RESP_OKAY);
    axi_rd(REG_STATUS, 32'hA, RESP_OKAY);
    axi_rd(8'h0C, 32'h0, RESP_SLVERR);
    axi_wr(8'h0C, 32'hFFFF, RESP_SLVERR);
  endtask
  task automatic t_ram();
    m.acc(1'b0, 1'b0, 1'b0, 1'b0, 12'h005, 18'h001A5);
    m.acc(1'b0, 1'b0, 1'b0, 1'b0, 12'h009, 18'h000AA);
    rd(1'b1, 1'b0, 12'h009, 32'h0AA);
    rd(1'b1, 1'b1, 12'h005, 32'h1A5);
    rd(1'b0, 1'b0, 12'h005, 32'h1A5);
    // Deselected write must not land, deselected read must not move the output.
    m.acc(1'b0, 1'b1, 1'b0, 1'b0, 12'h009, 18'h00055);
    m.acc(1'b1, 1'b1, 1'b1, 1'b0, 12'h009, 18'h00000);
    #1;
    chk(32'(b_rd), 32'h1A5);
    rd(1'b1, 1'b0, 12'h009, 32'h0AA);
  endtask
  task automatic t_width();
    axi_wr(REG_CTRL, ctl(1'b0, ESF_W18, ESF_W9), RESP_OKAY);
    m.acc(1'b0, 1'b0, 1'b0, 1'b0, 12'h003, WD);
    rd(1'b1, 1'b0, 12'h006, 32'(WD[8:0]));
    rd(1'b1, 1'b0, 12'h007, 32'(WD[17:9]));
    axi_wr(REG_CTRL, ctl(1'b0, ESF_W18, ESF_W4), RESP_OKAY);
    rd(1'b1, 1'b0, 12'h00C, 32'(WD[3:0]));
    rd(1'b1, 1'b0, 12'h00D, 32'(WD[7:4]));
    axi_wr(REG_CTRL, ctl(1'b0, ESF_W1, ESF_W9), RESP_OKAY);
    m.acc(1'b0, 1'b0, 1'b0, 1'b0, 12'h032, 18'h00001);
    rd(1'b1, 1'b0, 12'h006, 32'(WD[8:0]) | 32'h4);
  endtask
  task automatic t_fifo();
    axi_wr(REG_CTRL, ctl(1'b1, ESF_W9, ESF_W9), RESP_OKAY);
    axi_wr(REG_THRESH, 32'h00080010, RESP_OKAY);
    axi_rd(REG_THRESH, 32'h00080010, RESP_OKAY);
    m.acc(1'b0, 1'b0, 1'b0, 1'b0, 12'hFFF, 18'h00111);
    #1;
    chk(32'(flags), 32'h1);
    m.acc(1'b0, 1'b0, 1'b0, 1'b0, 12'h000, 18'h00122);
    axi_rd(REG_STATUS, (32'h10 << STAT_LV_LSB) | 32'h4, RESP_OKAY);
    rd(1'b1, 1'b0, 12'hABC, 32'h111);
    rd(1'b1, 1'b0, 12'hABC, 32'h122);
    chk(32'(flags), 32'h5);
    // Fill with 18-bit words; every half is 1A5, so address 005 still holds what RAM left there.
    axi_wr(REG_CTRL, ctl(1'b1, ESF_W18, ESF_W18), RESP_OKAY);
    repeat (257) m.acc(1'b0, 1'b0, 1'b0, 1'b0, 12'h000, 18'h34BA5);
    axi_rd(REG_STATUS, (32'h1000 << STAT_LV_LSB) | 32'h5, RESP_OKAY);
    axi_wr(REG_CTRL, ctl(1'b1, ESF_W18, ESF_W18) | (32'h1 << CTRL_CLEAR), RESP_OKAY);
    #1;
    chk(32'(flags), 32'h5);
    rd(1'b1, 1'b0, 12'h000, 32'h122);
  endtask
  task automatic t_rerst();
    @(posedge clock_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    #1;
    chk(32'(b_rd), 32'h0);
    chk(32'(flags), 32'h5);
    axi_rd(REG_CTRL, ctl(1'b0, ESF_W9, ESF_W9), RESP_OKAY);
    rd(1'b1, 1'b0, 12'h005, 32'h1A5);
  endtask

  // Reset for 12 cycles, then run every scenario once.
  initial begin
    repeat (12) @(posedge clock_i);
    srst_i <= 1'b0;
    #1;
    t_reset();
    t_ram();
    t_width();
    t_fifo();
    t_rerst();
    end_sim();
  end
endmodule
